// *** fsq_pkg.sv ***
// Constants, types and the address map of the flash program/erase sequencer.
// Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register port.
package fsq_pkg;
    // Address map (byte addresses)
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] ARR_BYTES = 12'h200;
    localparam logic [11:0] STAT_OFF = 12'h400;
    localparam logic [11:0] CTRL_OFF = 12'h404;
    localparam int unsigned CTRL_WEN_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    // Array geometry: 8 sectors of 16 half-words, one half-word per bus word
    localparam int unsigned SECT_N = 8;
    localparam int unsigned SECT_HW = 16;
    localparam int unsigned ARR_N = SECT_N * SECT_HW;
    localparam int unsigned IDX_W = 7;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned SECT_LSB = 6;
    localparam int unsigned SECT_MSB = 8;
    localparam logic [15:0] ERASED_HW = 16'hffff;

    // Command codes, taken from wdata[7:0]
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_PROG = 8'ha0;
    localparam logic [7:0] CMD_CHIP = 8'h10;
    localparam logic [7:0] CMD_SECT = 8'h30;
    localparam logic [7:0] CMD_SUSP = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h50;

    // Timing
    localparam int unsigned CLK_NS = 8;
    localparam int unsigned ERASE_WIN_NS = 35000;
    localparam int unsigned ERASE_WIN_CYC = (ERASE_WIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RESUME_NS = 2000000;
    localparam int unsigned RESUME_CYC = RESUME_NS / CLK_NS + 1;
    localparam int unsigned PROG_CYC = 16;
    localparam int unsigned ERASE_CYC = 64;
    localparam int unsigned TLIM_CYC = 1000000;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_PROG = 7'h02,
        ST_CERASE = 7'h04,
        ST_SWIN = 7'h08,
        ST_SERASE = 7'h10,
        ST_SUSP = 7'h20,
        ST_RESUME = 7'h40
    } fsq_state_e;

    // Status flags, bits 7..2 of a flag read
    typedef struct packed {
        logic pol;
        logic tog;
        logic tlim;
        logic rsv;
        logic win;
        logic tog2;
    } fsq_flags_s;

    // Status register layout
    typedef struct packed {
        logic [8:0] rsv_hi;
        logic [6:0] state;
        logic [7:0] sect_set;
        logic [5:0] rsv_lo;
        logic hang;
        logic busy;
    } fsq_stat_s;
endpackage : fsq_pkg

// *** fsq_seq.sv ***
// Flash program/erase sequencer with its array, reached over AXI4-Lite.
// Assumes a single 125 MHz clock and one master issuing command words.
//
// Operation
// - Reset and successful completion land in idle
// - Idle reads return array data directly
// - Accepted program runs alone to completion or, if it would raise a 0 bit, to the time limit
// - Busy program reads inverted bit 7
// - One half-word programmed per command sequence
// - Commands ignored while programming
// - Polarity flag holds inverted when time-limit flag sets
// - Chip erase wipes every sector at once
// - Chip erase reads flags, bit 7 done
// - Finished erase returns to idle
// - Sector erase waits window before erasing
// - Sector code inside window adds sector
// - Sector erase flags show completion, toggle
// - Only sector and suspend codes in window, only suspend while erasing
// - Suspend code pauses window or erase
// - Suspend halts window and erase at once
// - Chip erase and suspended not suspendable
// - Suspended: queued sectors flags, others data
// - Suspended ignores new program and erase
// - Resume goes to erasing, never window
// - Resume accepted only while suspended
// - Erasing restarts over 2 ms after resume
// - Busy flag reads alternate toggle bit until time limit trips
// - Over-time sets time-limit, hangs until reset
// - Window flag zero inside window, one after
`timescale 1ns/10ps
module fsq_seq #(
    parameter int unsigned WIN_CYC = fsq_pkg::ERASE_WIN_CYC,
    parameter int unsigned RESUME_CYC = fsq_pkg::RESUME_CYC,
    parameter int unsigned TLIM_CYC = fsq_pkg::TLIM_CYC
) (
    input wire logic i_core_clk,              // Core clock
    input wire logic i_nrst,                  // Async reset, active low
    input wire logic [11:0] i_s_axi_awaddr,   // Write address
    input wire logic i_s_axi_awvalid,         // Write address valid
    output logic o_s_axi_awready,             // Write address ready
    input wire logic [31:0] i_s_axi_wdata,    // Write data
    input wire logic [3:0] i_s_axi_wstrb,     // Write byte strobes
    input wire logic i_s_axi_wvalid,          // Write data valid
    output logic o_s_axi_wready,              // Write data ready
    output logic [1:0] o_s_axi_bresp,         // Write response
    output logic o_s_axi_bvalid,              // Write response valid
    input wire logic i_s_axi_bready,          // Write response ready
    input wire logic [11:0] i_s_axi_araddr,   // Read address
    input wire logic i_s_axi_arvalid,         // Read address valid
    output logic o_s_axi_arready,             // Read address ready
    output logic [31:0] o_s_axi_rdata,        // Read data
    output logic [1:0] o_s_axi_rresp,         // Read response
    output logic o_s_axi_rvalid,              // Read data valid
    input wire logic i_s_axi_rready           // Read data ready
);

    fsq_pkg::fsq_state_e state_q, state_d;
    logic [15:0] mem_q [fsq_pkg::ARR_N];
    logic [31:0] op_cnt_q, op_cnt_d;
    logic [31:0] res_cnt_q, res_cnt_d;
    logic [31:0] pulse_cnt_q, pulse_cnt_d;
    logic tl_q, tl_d;
    logic tog_q;
    logic armed_q, armed_d;
    logic [7:0] set_q, set_d;
    logic [15:0] prog_word_q;
    logic [6:0] prog_idx_q;
    logic [31:0] ctrl_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // Write channel: address and data are taken together
    wire wr_go = i_s_axi_awvalid && i_s_axi_wvalid && !bvalid_q;
    wire wr_arr = i_s_axi_awaddr < fsq_pkg::ARR_BYTES;
    wire wr_ctrl = wr_go && (i_s_axi_awaddr == fsq_pkg::CTRL_OFF);
    wire wr_ok = wr_arr || (i_s_axi_awaddr == fsq_pkg::CTRL_OFF)
                 || (i_s_axi_awaddr == fsq_pkg::STAT_OFF);
    // Byte writes to the array are dropped: commands need a full half-word
    wire cmd_v = wr_go && wr_arr && (i_s_axi_wstrb[1:0] == 2'b11)
                 && ctrl_q[fsq_pkg::CTRL_WEN_BIT];
    wire [7:0] cmd_code = i_s_axi_wdata[7:0];
    wire [6:0] w_idx = i_s_axi_awaddr[fsq_pkg::SECT_MSB:fsq_pkg::IDX_LSB];
    wire [2:0] w_sect = i_s_axi_awaddr[fsq_pkg::SECT_MSB:fsq_pkg::SECT_LSB];
    wire sect_cmd = cmd_v && (cmd_code == fsq_pkg::CMD_SECT);
    wire sus_cmd = cmd_v && (cmd_code == fsq_pkg::CMD_SUSP);
    wire res_cmd = cmd_v && (cmd_code == fsq_pkg::CMD_RESUME);
    wire hang_clr = tl_q && cmd_v && (cmd_code == fsq_pkg::CMD_RESET);
    wire prog_go = (state_q == fsq_pkg::ST_IDLE) && cmd_v && armed_q;

    assign o_s_axi_awready = wr_go;
    assign o_s_axi_wready = wr_go;

    // Internal algorithm timing
    wire [15:0] prog_cell = mem_q[prog_idx_q];
    wire [15:0] prog_val = prog_cell & prog_word_q;
    // A 0 cell cannot be raised to 1: such a program never completes
    wire prog_bad = |(~prog_cell & prog_word_q);
    wire [31:0] phase_lim = (state_q == fsq_pkg::ST_PROG) ? 32'(fsq_pkg::PROG_CYC)
                          : (state_q == fsq_pkg::ST_SWIN) ? 32'(WIN_CYC)
                          : 32'(fsq_pkg::ERASE_CYC);
    wire phase_end = (op_cnt_q == phase_lim - 32'h1) && !tl_q;
    wire win_end = phase_end && (state_q == fsq_pkg::ST_SWIN);
    wire res_end = res_cnt_q == 32'(RESUME_CYC) - 32'h1;
    wire cnt_run = !tl_q && (state_q inside {fsq_pkg::ST_PROG, fsq_pkg::ST_CERASE,
                                             fsq_pkg::ST_SWIN, fsq_pkg::ST_SERASE});
    // Resume delay counts against the time limit, so fast suspend cycles can hang
    wire pulse_run = !tl_q && (state_q inside {fsq_pkg::ST_PROG, fsq_pkg::ST_CERASE,
                                               fsq_pkg::ST_SERASE, fsq_pkg::ST_RESUME});

    always_comb begin
        state_d = state_q;
        case (state_q)
            fsq_pkg::ST_IDLE: begin
                if (prog_go) begin
                    state_d = fsq_pkg::ST_PROG;
                end else if (cmd_v && cmd_code == fsq_pkg::CMD_CHIP) begin
                    state_d = fsq_pkg::ST_CERASE;
                end else if (sect_cmd) begin
                    state_d = fsq_pkg::ST_SWIN;
                end
            end
            fsq_pkg::ST_PROG: begin
                if (phase_end && !prog_bad) begin
                    state_d = fsq_pkg::ST_IDLE;
                end
            end
            fsq_pkg::ST_CERASE: begin
                if (phase_end) begin
                    state_d = fsq_pkg::ST_IDLE;
                end
            end
            fsq_pkg::ST_SWIN: begin
                if (sus_cmd) begin
                    state_d = fsq_pkg::ST_SUSP;
                end else if (win_end && !sect_cmd) begin
                    state_d = fsq_pkg::ST_SERASE;
                end
            end
            fsq_pkg::ST_SERASE: begin
                if (sus_cmd) begin
                    state_d = fsq_pkg::ST_SUSP;
                end else if (phase_end) begin
                    state_d = fsq_pkg::ST_IDLE;
                end
            end
            fsq_pkg::ST_SUSP: begin
                if (res_cmd) begin
                    state_d = fsq_pkg::ST_RESUME;
                end
            end
            fsq_pkg::ST_RESUME: begin
                if (sus_cmd) begin
                    state_d = fsq_pkg::ST_SUSP;
                end else if (res_end) begin
                    state_d = fsq_pkg::ST_SERASE;
                end
            end
            default: begin
                state_d = fsq_pkg::ST_IDLE;
            end
        endcase
        if (tl_q) begin
            state_d = hang_clr ? fsq_pkg::ST_IDLE : state_q;
        end
    end

    wire prog_done = (state_q == fsq_pkg::ST_PROG) && (state_d == fsq_pkg::ST_IDLE) && !tl_q;
    wire erase_done = (state_q inside {fsq_pkg::ST_CERASE, fsq_pkg::ST_SERASE})
                      && (state_d == fsq_pkg::ST_IDLE) && !tl_q;

    always_comb begin
        // Window progress is dropped on leaving it: erase starts from zero, but a resumed erase keeps its held count
        if (state_q == fsq_pkg::ST_IDLE
            || (state_q == fsq_pkg::ST_SWIN && (state_d != fsq_pkg::ST_SWIN || sect_cmd))) begin
            op_cnt_d = 32'h0;
        end else if (cnt_run) begin
            op_cnt_d = op_cnt_q + 32'h1;
        end else begin
            op_cnt_d = op_cnt_q;
        end
        res_cnt_d = (state_q == fsq_pkg::ST_RESUME && state_d == fsq_pkg::ST_RESUME)
                    ? res_cnt_q + 32'h1 : 32'h0;
        if (state_q == fsq_pkg::ST_IDLE) begin
            pulse_cnt_d = 32'h0;
        end else if (pulse_run) begin
            pulse_cnt_d = pulse_cnt_q + 32'h1;
        end else begin
            pulse_cnt_d = pulse_cnt_q;
        end
        tl_d = tl_q;
        if (hang_clr) begin
            tl_d = 1'b0;
        end else if (pulse_run && pulse_cnt_q == 32'(TLIM_CYC) - 32'h1) begin
            tl_d = 1'b1;
        end
        armed_d = armed_q;
        if (prog_go || tl_q) begin
            armed_d = 1'b0;
        end else if (state_q == fsq_pkg::ST_IDLE && cmd_v) begin
            armed_d = cmd_code == fsq_pkg::CMD_PROG;
        end
        set_d = set_q;
        if (erase_done || hang_clr) begin
            set_d = 8'h00;
        end else if (state_q == fsq_pkg::ST_IDLE && !armed_q && cmd_v
                     && cmd_code == fsq_pkg::CMD_CHIP) begin
            set_d = 8'hff;
        end else if (sect_cmd && !armed_q && !tl_q
                     && state_q inside {fsq_pkg::ST_IDLE, fsq_pkg::ST_SWIN}) begin
            set_d = set_q | (8'h01 << w_sect);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= fsq_pkg::ST_IDLE;
            op_cnt_q <= 32'h0;
            res_cnt_q <= 32'h0;
            pulse_cnt_q <= 32'h0;
            tl_q <= 1'b0;
            armed_q <= 1'b0;
            set_q <= 8'h00;
        end else begin
            state_q <= state_d;
            op_cnt_q <= op_cnt_d;
            res_cnt_q <= res_cnt_d;
            pulse_cnt_q <= pulse_cnt_d;
            tl_q <= tl_d;
            armed_q <= armed_d;
            set_q <= set_d;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prog_word_q <= 16'h0000;
            prog_idx_q <= 7'h00;
        end else if (prog_go) begin
            prog_word_q <= i_s_axi_wdata[15:0];
            prog_idx_q <= w_idx;
        end
    end

    // Array cells; reset leaves them erased so simulation starts from a known image
    for (genvar gi = 0; gi < fsq_pkg::ARR_N; gi++) begin : g_cell
        always_ff @(posedge i_core_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                mem_q[gi] <= fsq_pkg::ERASED_HW;
            end else if (prog_done && prog_idx_q == 7'(gi)) begin
                mem_q[gi] <= prog_val;
            end else if (erase_done && set_q[gi / fsq_pkg::SECT_HW]) begin
                mem_q[gi] <= fsq_pkg::ERASED_HW;
            end
        end
    end

    // Read channel
    wire rd_go = i_s_axi_arvalid && !rvalid_q;
    wire rd_arr = i_s_axi_araddr < fsq_pkg::ARR_BYTES;
    wire [6:0] rd_idx = i_s_axi_araddr[fsq_pkg::SECT_MSB:fsq_pkg::IDX_LSB];
    wire [2:0] rd_sect = i_s_axi_araddr[fsq_pkg::SECT_MSB:fsq_pkg::SECT_LSB];
    wire [15:0] rd_cell = mem_q[rd_idx];
    wire rd_queued = (state_q == fsq_pkg::ST_SUSP) && set_q[rd_sect];
    wire show_flags = (state_q != fsq_pkg::ST_IDLE)
                      && ((state_q != fsq_pkg::ST_SUSP) || rd_queued);
    // Toggle freezes high once the time limit trips
    wire tog_v = tl_q | tog_q;
    fsq_pkg::fsq_flags_s flags;
    fsq_pkg::fsq_stat_s stat;

    always_comb begin
        flags = '0;
        case (state_q)
            fsq_pkg::ST_PROG: begin
                flags.pol = ~prog_word_q[7];
                flags.tog = tog_v;
                flags.tlim = tl_q;
            end
            fsq_pkg::ST_SWIN: begin
                flags.tog = tog_v;
                flags.tog2 = tog_v;
            end
            fsq_pkg::ST_CERASE, fsq_pkg::ST_SERASE, fsq_pkg::ST_RESUME: begin
                flags.tog = tog_v;
                flags.tlim = tl_q;
                flags.win = 1'b1;
                flags.tog2 = tog_v;
            end
            fsq_pkg::ST_SUSP: begin
                flags.win = 1'b1;
                flags.tog2 = tog_q;
            end
            default: begin
                flags = '0;
            end
        endcase
    end

    always_comb begin
        stat = '0;
        stat.state = state_q;
        stat.sect_set = set_q;
        stat.hang = tl_q;
        stat.busy = state_q != fsq_pkg::ST_IDLE;
    end

    wire [31:0] arr_word = show_flags ? {24'h000000, flags, 2'b00} : {16'h0000, rd_cell};
    wire [31:0] rd_word = rd_arr ? arr_word
                        : (i_s_axi_araddr == fsq_pkg::STAT_OFF) ? stat
                        : (i_s_axi_araddr == fsq_pkg::CTRL_OFF) ? ctrl_q : 32'h0;
    wire rd_ok = rd_arr || (i_s_axi_araddr == fsq_pkg::STAT_OFF)
                 || (i_s_axi_araddr == fsq_pkg::CTRL_OFF);

    assign o_s_axi_arready = rd_go;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tog_q <= 1'b0;
        end else if (rd_go && rd_arr && show_flags) begin
            tog_q <= ~tog_q;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= fsq_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_ok ? fsq_pkg::RESP_OKAY : fsq_pkg::RESP_SLVERR;
        end else if (i_s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bvalid_q <= 1'b0;
            bresp_q <= fsq_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? fsq_pkg::RESP_OKAY : fsq_pkg::RESP_SLVERR;
        end else if (i_s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_q <= fsq_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= {31'h0, i_s_axi_wdata[fsq_pkg::CTRL_WEN_BIT]};
        end
    end

    assign o_s_axi_bvalid = bvalid_q;
    assign o_s_axi_bresp = bresp_q;
    assign o_s_axi_rvalid = rvalid_q;
    assign o_s_axi_rdata = rdata_q;
    assign o_s_axi_rresp = rresp_q;

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_flag_read(fsq_pkg::fsq_state_e st);
        rd_go && rd_arr && state_q == st;
    endsequence

    sequence s_suspend_taken;
        sus_cmd && !tl_q && state_q inside {fsq_pkg::ST_SWIN, fsq_pkg::ST_SERASE};
    endsequence

    AST_IDLE_READS_DATA: assert property (
        s_flag_read(fsq_pkg::ST_IDLE) |=> o_s_axi_rvalid && o_s_axi_rdata[15:0] == $past(rd_cell))
        else $error("idle read did not return array data");
    AST_PROG_POLARITY: assert property (
        s_flag_read(fsq_pkg::ST_PROG) |=> o_s_axi_rdata[7] == !prog_word_q[7])
        else $error("busy program read bit 7 not inverted");
    AST_PROG_DONE: assert property (
        prog_done |=> state_q == fsq_pkg::ST_IDLE && prog_cell == $past(prog_val))
        else $error("program did not store the half-word");
    AST_PROG_IGNORES: assert property (
        state_q == fsq_pkg::ST_PROG && cmd_v && !tl_q |=> $stable(prog_word_q) && $stable(set_q))
        else $error("command taken while programming");
    AST_WIN_EXPIRES: assert property (
        state_q == fsq_pkg::ST_SWIN && win_end && !cmd_v |=> state_q == fsq_pkg::ST_SERASE)
        else $error("window end did not start erasing");
    AST_WIN_FLAG_LOW: assert property (
        s_flag_read(fsq_pkg::ST_SWIN) |=> o_s_axi_rdata[3] == 1'b0 && o_s_axi_rdata[7] == 1'b0)
        else $error("window flag high inside window");
    AST_SUSPEND_HALTS: assert property (
        s_suspend_taken |=> state_q == fsq_pkg::ST_SUSP ##1 $stable(op_cnt_q))
        else $error("suspend did not halt the operation");
    AST_SUSP_IGNORES: assert property (
        state_q == fsq_pkg::ST_SUSP && cmd_v && cmd_code != fsq_pkg::CMD_RESUME
        |=> state_q == fsq_pkg::ST_SUSP && $stable(set_q))
        else $error("command taken while suspended");
    AST_RESUME_DELAY: assert property (
        state_q == fsq_pkg::ST_SERASE && $past(state_q) == fsq_pkg::ST_RESUME
        |-> $past(res_cnt_q) == 32'(RESUME_CYC) - 32'h1)
        else $error("erase restarted before resume delay");
    AST_HANG_HOLDS: assert property (
        tl_q && !hang_clr |=> tl_q && $stable(state_q))
        else $error("hang left without reset command");

endmodule : fsq_seq

// *** fsq_master.sv ***
// AXI4-Lite master standing in for the CPU that issues flash command words.
// Assumes one clock; the sequencer's answer is awaited without a cycle count.
`timescale 1ns/10ps
module fsq_master (
    input wire logic i_clk,                    // Core clock
    input wire logic i_awready,                // Write address taken
    input wire logic i_wready,                 // Write data taken
    input wire logic i_bvalid,                 // Write response valid
    input wire logic [1:0] i_bresp,            // Write response
    input wire logic i_arready,                // Read address taken
    input wire logic i_rvalid,                 // Read data valid
    input wire logic [31:0] i_rdata,           // Read data
    input wire logic [1:0] i_rresp,            // Read response
    output logic [11:0] o_awaddr = 12'h000,    // Write address
    output logic o_awvalid = 1'b0,             // Write address valid
    output logic [31:0] o_wdata = 32'h0,       // Write data
    output logic [3:0] o_wstrb = 4'hf,         // Whole-word strobes
    output logic o_wvalid = 1'b0,              // Write data valid
    output logic o_bready = 1'b0,              // Write response ready
    output logic [11:0] o_araddr = 12'h000,    // Read address
    output logic o_arvalid = 1'b0,             // Read address valid
    output logic o_rready = 1'b0               // Read data ready
);
    // One half-word per sequence: every call is one whole command word
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        o_awaddr <= a;
        o_wdata <= d;
        o_awvalid <= 1'b1;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        // Each channel is released at its own handshake, in either order
        fork
            begin
                do @(posedge i_clk); while (i_awready !== 1'b1);
                o_awvalid <= 1'b0;
            end
            begin
                do @(posedge i_clk); while (i_wready !== 1'b1);
                o_wvalid <= 1'b0;
            end
        join
        while (i_bvalid !== 1'b1) @(posedge i_clk);
        r = i_bresp;
        o_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        o_araddr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        do @(posedge i_clk); while (i_arready !== 1'b1);
        o_arvalid <= 1'b0;
        while (i_rvalid !== 1'b1) @(posedge i_clk);
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
    endtask : rd
endmodule : fsq_master

// *** flash_program_erase_sequencer_test.sv ***
// Self-checking bench for the flash sequencer, driven by the bus master model.
// Assumes short window, resume and time-limit counts set below.
`timescale 1ns/10ps
module flash_program_erase_sequencer_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int n_mismatch = 0;
    int total_checks = 0;
    localparam logic [11:0] ST = fsq_pkg::STAT_OFF;

    always #4 clk = ~clk;

    fsq_master m (.i_clk(clk), .i_awready(awready), .i_wready(wready), .i_bvalid(bvalid),
        .i_bresp(bresp), .i_arready(arready), .i_rvalid(rvalid), .i_rdata(rdata),
        .i_rresp(rresp),
        .o_awaddr(awaddr), .o_awvalid(awvalid), .o_wdata(wdata), .o_wstrb(wstrb),
        .o_wvalid(wvalid), .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
        .o_rready(rready));

    fsq_seq #(.WIN_CYC(20), .RESUME_CYC(10), .TLIM_CYC(400)) dut (.i_core_clk(clk),
        .i_nrst(nrst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Ignored commands still answer OKAY, so every write checks its response
    task automatic w(logic [11:0] a, logic [31:0] d);
        logic [1:0] r;
        m.wr(a, d, r);
        chk("bresp", 32'h0, {30'h0, r});
    endtask : w

    task automatic rchk(string nm, logic [11:0] a, logic [31:0] msk, logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        m.rd(a, d, r);
        chk(nm, e, d & msk);
    endtask : rchk

    task automatic t_idle;
        logic [31:0] d;
        logic [1:0] r;
        rchk("array", 12'h010, 32'hffffffff, 32'h0000ffff);
        rchk("state", ST, 32'h007f0000, 32'h00010000);
        m.rd(12'h800, d, r);
        chk("unmapped", {30'h0, fsq_pkg::RESP_SLVERR}, {30'h0, r});
        rchk("ctrl", fsq_pkg::CTRL_OFF, 32'hffffffff, fsq_pkg::CTRL_RST);
        // Commands are dropped while the enable bit is clear
        w(fsq_pkg::CTRL_OFF, 32'h0);
        w(12'h010, {24'h0, fsq_pkg::CMD_CHIP});
        rchk("disabled", ST, 32'h007f0000, 32'h00010000);
        w(fsq_pkg::CTRL_OFF, fsq_pkg::CTRL_RST);
    endtask : t_idle

    task automatic t_prog;
        logic [31:0] d1, d2;
        logic [1:0] r;
        w(12'h010, {24'h0, fsq_pkg::CMD_PROG});
        w(12'h010, 32'h1234);
        m.rd(12'h010, d1, r);
        m.rd(12'h010, d2, r);
        chk("polarity", 32'h80, d1 & 32'h80);
        chk("toggle", {31'h0, ~d1[6]}, {31'h0, d2[6]});
        w(12'h014, {24'h0, fsq_pkg::CMD_PROG});
        repeat (30) @(posedge clk);
        w(12'h014, 32'h0);
        rchk("written", 12'h010, 32'hffffffff, 32'h1234);
        rchk("ignored", 12'h014, 32'hffffffff, 32'hffff);
        rchk("state", ST, 32'h007f0000, 32'h00010000);
    endtask : t_prog

    task automatic t_sect;
        w(12'h010, {24'h0, fsq_pkg::CMD_SECT});
        rchk("window", 12'h010, 32'h88, 32'h00);
        w(12'h044, {24'h0, fsq_pkg::CMD_SECT});
        w(12'h084, {24'h0, fsq_pkg::CMD_SUSP});
        rchk("susp", ST, 32'h007fff00, 32'h00200300);
        rchk("queued", 12'h010, 32'hc8, 32'h08);
        rchk("other", 12'h084, 32'hffffffff, 32'hffff);
        w(12'h084, {24'h0, fsq_pkg::CMD_PROG});
        w(12'h084, 32'h0);
        w(12'h010, {24'h0, fsq_pkg::CMD_SUSP});
        rchk("other", 12'h084, 32'hffffffff, 32'hffff);
        w(12'h010, {24'h0, fsq_pkg::CMD_RESUME});
        rchk("resume", ST, 32'h007f0000, 32'h00400000);
        repeat (12) @(posedge clk);
        w(12'h010, {24'h0, fsq_pkg::CMD_RESUME});
        rchk("erasing", ST, 32'h007f0000, 32'h00100000);
        rchk("erflags", 12'h084, 32'h88, 32'h08);
        repeat (80) @(posedge clk);
        rchk("erased", 12'h010, 32'hffffffff, 32'hffff);
        rchk("state", ST, 32'h007fff00, 32'h00010000);
        // Let a window run out: erasing must start on its own
        w(12'h084, {24'h0, fsq_pkg::CMD_SECT});
        repeat (24) @(posedge clk);
        rchk("expired", 12'h084, 32'h88, 32'h08);
        rchk("started", ST, 32'h007fff00, 32'h00100400);
        repeat (80) @(posedge clk);
        rchk("state", ST, 32'h007fff00, 32'h00010000);
    endtask : t_sect

    task automatic t_chip;
        w(12'h100, {24'h0, fsq_pkg::CMD_PROG});
        w(12'h100, 32'h00aa);
        repeat (30) @(posedge clk);
        w(12'h000, {24'h0, fsq_pkg::CMD_CHIP});
        rchk("cflags", 12'h1fc, 32'h88, 32'h08);
        w(12'h000, {24'h0, fsq_pkg::CMD_SUSP});
        rchk("chip", ST, 32'h007f0000, 32'h00040000);
        repeat (80) @(posedge clk);
        rchk("erased", 12'h100, 32'hffffffff, 32'hffff);
        rchk("state", ST, 32'h007f0000, 32'h00010000);
    endtask : t_chip

    task automatic t_hang;
        w(12'h100, {24'h0, fsq_pkg::CMD_PROG});
        w(12'h100, 32'h0);
        repeat (30) @(posedge clk);
        w(12'h100, {24'h0, fsq_pkg::CMD_PROG});
        w(12'h100, 32'h1);
        repeat (420) @(posedge clk);
        rchk("hang", ST, 32'h3, 32'h3);
        rchk("tlim", 12'h100, 32'h60, 32'h60);
        rchk("tlim", 12'h100, 32'h60, 32'h60);
        w(12'h100, {24'h0, fsq_pkg::CMD_CHIP});
        rchk("hang", ST, 32'h007f0003, 32'h00020003);
        w(12'h100, {24'h0, fsq_pkg::CMD_RESET});
        rchk("reset", ST, 32'h007f0003, 32'h00010000);
        rchk("kept", 12'h100, 32'hffffffff, 32'h0);
    endtask : t_hang

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_idle();
        t_prog();
        t_sect();
        t_chip();
        t_hang();
        close_out();
    end

    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end
endmodule : flash_program_erase_sequencer_test
